//--- shared/tmb_params.svh
// byte-map locations, field positions, reset values and timing counts of the 16-bit timer
// assumes inclusion by bare name from packages and modules alike
`ifndef TMB_PARAMS_SVH
`define TMB_PARAMS_SVH
// byte locations on the 8-bit port (index into the 4-bit address)
`define TMB_ADDR_CTRL_A      4'h0
`define TMB_ADDR_CTRL_B      4'h1
`define TMB_ADDR_COUNT_LO    4'h2
`define TMB_ADDR_COUNT_HI    4'h3
`define TMB_ADDR_CMPA_LO     4'h4
`define TMB_ADDR_CMPA_HI     4'h5
`define TMB_ADDR_CMPB_LO     4'h6
`define TMB_ADDR_CMPB_HI     4'h7
`define TMB_ADDR_CAPT_LO     4'h8
`define TMB_ADDR_CAPT_HI     4'h9
`define TMB_ADDR_FLAGS       4'hA
`define TMB_ADDR_MASK        4'hB
// control a fields
`define TMB_CA_FORCE_A       7
`define TMB_CA_FORCE_B       6
`define TMB_CA_WAVE1         1
`define TMB_CA_WAVE0         0
// control b fields
`define TMB_CB_CAPT_NOISE    7
`define TMB_CB_CAPT_EDGE     6
`define TMB_CB_CAPT_ACOMP    5
`define TMB_CB_WAVE3         4
`define TMB_CB_WAVE2         3
`define TMB_CB_CS_HI         2
// flag and mask bit positions
`define TMB_FL_CAPTURE       5
`define TMB_FL_CMP_A         4
`define TMB_FL_CMP_B         3
`define TMB_FL_OVERFLOW      2
// fixed values
`define TMB_BOTTOM           16'h0000
`define TMB_MAX              16'hFFFF
`define TMB_TOP_8BIT         16'h00FF
`define TMB_TOP_9BIT         16'h01FF
`define TMB_TOP_10BIT        16'h03FF
`define TMB_RST_BYTE         8'h00
`define TMB_RST_WORD         16'h0000
// noise filter length in clock cycles
`define TMB_NOISE_SAMPLES    4
`endif

//--- shared/tmb_pkg.sv
// types shared by the timer and its processor-side access end
// assumes tmb_params.svh is on the include path
package tmb_pkg;
  typedef enum logic [2:0] {
    TMB_CS_OFF, TMB_CS_DIV1, TMB_CS_DIV8, TMB_CS_DIV64,
    TMB_CS_DIV256, TMB_CS_DIV1024, TMB_CS_EXT_FALL, TMB_CS_EXT_RISE
  } tmb_clk_sel_t;
  typedef enum logic [1:0] {
    TMB_OP_IDLE, TMB_OP_WRITE, TMB_OP_READ
  } tmb_op_t;
endpackage

//--- shared/tmb_bus_if.sv
// byte-wide processor bus between the timer and its access end
// assumes one clock shared by both parties; strobes are single-cycle
`timescale 1ns/1ns
interface tmb_bus_if;
  logic [3:0] addr;
  logic       wr_en;
  logic       rd_en;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport timer (input addr, input wr_en, input rd_en, input wdata, output rdata);
  modport cpu   (output addr, output wr_en, output rd_en, output wdata, input rdata);
endinterface

//--- core/tmb_edge_sync.sv
// three-stage pin synchroniser with rise and fall pulses
// assumes an asynchronous pin; second and third stage must agree
`timescale 1ns/1ns
module tmb_edge_sync (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic pin_i,
  output logic      level_o,
  output logic      rise_o,
  output logic      fall_o
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic lvl_q;
  // metastability chain; s1 is read by s2 only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  // level moves only once the two late stages agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lvl_q <= 1'b0;
    end else if (s2_q == s3_q) begin
      lvl_q <= s3_q;
    end
  end
  assign level_o = lvl_q;
  assign rise_o  = (s2_q == s3_q) && s3_q && !lvl_q;
  assign fall_o  = (s2_q == s3_q) && !s3_q && lvl_q;
endmodule // tmb_edge_sync

//--- core/tmb_timer.sv
// 16-bit timer/counter with byte-wide access through a shared high-byte holding register
// assumes the access end keeps byte order and one clock; pins are asynchronous
//
// How it works
// - wide registers reached as two byte accesses
// - one shared eight-bit high-byte holding register
// - low write loads held high plus low
// - count or capture low read copies upper byte into holder
// - count high location maps to holder
// - compare reads bypass the holder entirely
// - writer sends high byte before low byte
// - reader fetches low byte before high
// - main code blocks interrupts around pairs
// - no clock source selected holds count
// - select prescaler tap or pin edge
// - compares checked against count on every timer clock tick
// - compare match sets its flag
// - requests in flag register, masked individually
// - capture edge latches count, optional filter
// - top from fixed values, compare a, capture
// - compare a as top is double buffered in pwm modes only
// - bottom at zero, max at all ones
// - legacy bits map onto wave mode bits
// - control registers are plain single bytes
`timescale 1ns/1ns
`include "tmb_params.svh"
module tmb_timer #(
  parameter int NOISE_SAMPLES = `TMB_NOISE_SAMPLES
) (
  input  wire logic  clk_i,
  input  wire logic  rst_i,
  tmb_bus_if.timer   bus,
  input  wire logic  external_clock_pin_i,
  input  wire logic  capture_pin_i,
  input  wire logic  acomp_out_i,
  output logic       compare_a_output_o,
  output logic       compare_b_output_o,
  output logic       irq_o,
  output logic       bottom_o,
  output logic       max_o
);
  logic [7:0]  hold_q;
  logic [7:0]  control_a_q;
  logic [7:0]  control_b_q;
  logic [15:0] count_value_q;
  logic [15:0] compare_a_value_q;
  logic [15:0] compare_b_value_q;
  logic [15:0] cmpa_buf_q;
  logic [15:0] cmpb_buf_q;
  logic [15:0] capture_value_q;
  logic [5:2]  flag_q;
  logic [5:2]  mask_q;
  logic [7:0]  rdata_q;
  logic [9:0]  presc_q;
  logic        ext_lvl;
  logic        ext_rise;
  logic        ext_fall;
  logic        cap_lvl;
  logic        acomp_lvl;
  logic        cap_filt_q;
  logic [3:0]  cap_cnt_q;
  logic        cap_prev_q;
  logic        oa_q;
  logic        ob_q;
  logic        tick;
  logic        wave_pwm;
  logic        cap_evt;
  logic        cap_src;
  logic        wr_lo;
  logic [3:0]  wave_mode;
  logic [15:0] top;
  logic        at_top;
  logic        match_a;
  logic        match_b;
  tmb_pkg::tmb_clk_sel_t cs;

  // clock-domain entry for the external clock and capture pins
  tmb_edge_sync u_ext_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   (external_clock_pin_i),
    .level_o (ext_lvl),
    .rise_o  (ext_rise),
    .fall_o  (ext_fall)
  );
  tmb_edge_sync u_cap_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   (capture_pin_i),
    .level_o (cap_lvl),
    .rise_o  (),
    .fall_o  ()
  );
  tmb_edge_sync u_acomp_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   (acomp_out_i),
    .level_o (acomp_lvl),
    .rise_o  (),
    .fall_o  ()
  );

  // legacy pwm and clear bits sit where the wave mode bits now live
  assign wave_mode = {control_b_q[`TMB_CB_WAVE3], control_b_q[`TMB_CB_WAVE2],
                      control_a_q[`TMB_CA_WAVE1], control_a_q[`TMB_CA_WAVE0]};
  assign cs        = tmb_pkg::tmb_clk_sel_t'(control_b_q[`TMB_CB_CS_HI:0]);
  assign wave_pwm  = (wave_mode[1:0] != 2'b00) || (wave_mode == 4'hE) || (wave_mode == 4'hF);

  // free-running prescaler, cleared by nothing but reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      presc_q <= 10'h000;
    end else begin
      presc_q <= presc_q + 10'h001;
    end
  end

  // timer clock from prescaler tap or synchronised pin edge
  always_comb begin
    case (cs)
      tmb_pkg::TMB_CS_OFF:      tick = 1'b0;
      tmb_pkg::TMB_CS_DIV1:     tick = 1'b1;
      tmb_pkg::TMB_CS_DIV8:     tick = (presc_q[2:0] == 3'h7);
      tmb_pkg::TMB_CS_DIV64:    tick = (presc_q[5:0] == 6'h3F);
      tmb_pkg::TMB_CS_DIV256:   tick = (presc_q[7:0] == 8'hFF);
      tmb_pkg::TMB_CS_DIV1024:  tick = (presc_q == 10'h3FF);
      tmb_pkg::TMB_CS_EXT_FALL: tick = ext_fall;
      default:                  tick = ext_rise;
    endcase
  end

  // top of the count sequence per wave mode
  always_comb begin
    case (wave_mode)
      4'h1, 4'h5:  top = `TMB_TOP_8BIT;
      4'h2, 4'h6:  top = `TMB_TOP_9BIT;
      4'h3, 4'h7:  top = `TMB_TOP_10BIT;
      4'h4, 4'hF, 4'h9, 4'hB: top = compare_a_value_q;
      4'h8, 4'hA, 4'hC, 4'hE: top = capture_value_q;
      default:     top = `TMB_MAX;
    endcase
  end
  assign at_top   = (count_value_q == top);
  assign bottom_o = (count_value_q == `TMB_BOTTOM);
  assign max_o    = (count_value_q == `TMB_MAX);
  assign match_a  = (count_value_q == compare_a_value_q);
  assign match_b  = (count_value_q == compare_b_value_q);
  assign wr_lo    = bus.wr_en && (bus.addr == `TMB_ADDR_COUNT_LO);

  // shared holder: high-byte writes land here, count and capture low reads refill it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_q <= `TMB_RST_BYTE;
    end else if (bus.wr_en && (bus.addr == `TMB_ADDR_COUNT_HI || bus.addr == `TMB_ADDR_CMPA_HI ||
                               bus.addr == `TMB_ADDR_CMPB_HI || bus.addr == `TMB_ADDR_CAPT_HI)) begin
      hold_q <= bus.wdata;
    end else if (bus.rd_en && bus.addr == `TMB_ADDR_COUNT_LO) begin
      hold_q <= count_value_q[15:8];
    end else if (bus.rd_en && bus.addr == `TMB_ADDR_CAPT_LO) begin
      hold_q <= capture_value_q[15:8];
    end
  end

  // counter: a processor write outranks counting; up-count only, wraps at top
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_value_q <= `TMB_RST_WORD;
    end else if (wr_lo) begin
      count_value_q <= {hold_q, bus.wdata};
    end else if (tick) begin
      count_value_q <= at_top ? `TMB_BOTTOM : count_value_q + 16'h0001;
    end
  end

  // compare buffers; pwm modes update the live value at top so top can move safely
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmpa_buf_q        <= `TMB_RST_WORD;
      cmpb_buf_q        <= `TMB_RST_WORD;
      compare_a_value_q <= `TMB_RST_WORD;
      compare_b_value_q <= `TMB_RST_WORD;
    end else begin
      if (bus.wr_en && bus.addr == `TMB_ADDR_CMPA_LO) begin
        cmpa_buf_q <= {hold_q, bus.wdata};
      end
      if (bus.wr_en && bus.addr == `TMB_ADDR_CMPB_LO) begin
        cmpb_buf_q <= {hold_q, bus.wdata};
      end
      if (!wave_pwm || (tick && at_top)) begin
        compare_a_value_q <= cmpa_buf_q;
        compare_b_value_q <= cmpb_buf_q;
      end
    end
  end

  // capture source, optional majority-free run-length filter, edge select
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cap_filt_q <= 1'b0;
      cap_cnt_q  <= 4'h0;
      cap_prev_q <= 1'b0;
    end else begin
      if (!control_b_q[`TMB_CB_CAPT_NOISE] || cap_src == cap_filt_q) begin
        cap_cnt_q  <= 4'h0;
        cap_filt_q <= control_b_q[`TMB_CB_CAPT_NOISE] ? cap_filt_q : cap_src;
      end else if (cap_cnt_q == 4'(NOISE_SAMPLES - 1)) begin
        cap_cnt_q  <= 4'h0;
        cap_filt_q <= cap_src;
      end else begin
        cap_cnt_q <= cap_cnt_q + 4'h1;
      end
      cap_prev_q <= cap_filt_q;
    end
  end
  assign cap_src = control_b_q[`TMB_CB_CAPT_ACOMP] ? acomp_lvl : cap_lvl;
  assign cap_evt = control_b_q[`TMB_CB_CAPT_EDGE] ? (cap_filt_q && !cap_prev_q)
                                                   : (!cap_filt_q && cap_prev_q);

  // capture register: latched by events, also while it serves as top; a low write wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      capture_value_q <= `TMB_RST_WORD;
    end else if (bus.wr_en && bus.addr == `TMB_ADDR_CAPT_LO) begin
      capture_value_q <= {hold_q, bus.wdata};
    end else if (cap_evt) begin
      capture_value_q <= count_value_q;
    end
  end

  // plain byte control registers; force bits are strobes and read back as zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      control_a_q <= `TMB_RST_BYTE;
      control_b_q <= `TMB_RST_BYTE;
      mask_q      <= 4'h0;
    end else begin
      if (bus.wr_en && bus.addr == `TMB_ADDR_CTRL_A) begin
        control_a_q <= {2'b00, bus.wdata[5:0]};
      end
      if (bus.wr_en && bus.addr == `TMB_ADDR_CTRL_B) begin
        control_b_q <= bus.wdata;
      end
      if (bus.wr_en && bus.addr == `TMB_ADDR_MASK) begin
        mask_q <= bus.wdata[5:2];
      end
    end
  end

  // flags: write one to clear, but a same-cycle event wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_q <= 4'h0;
    end else begin
      flag_q <= ((bus.wr_en && bus.addr == `TMB_ADDR_FLAGS) ? (flag_q & ~bus.wdata[5:2]) : flag_q)
              | {cap_evt, tick && match_a, tick && match_b, tick && at_top};
    end
  end
  assign irq_o = |(flag_q & mask_q);

  // compare outputs toggle on match or on a force strobe; compare a output holds in pwm modes 9, B, F (compare a as top) and D
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      oa_q <= 1'b0;
      ob_q <= 1'b0;
    end else begin
      if (!(wave_pwm && wave_mode[3] && wave_mode[0]) &&
          ((tick && match_a) || (bus.wr_en && bus.addr == `TMB_ADDR_CTRL_A && bus.wdata[`TMB_CA_FORCE_A]))) begin
        oa_q <= !oa_q;
      end
      if ((tick && match_b) || (bus.wr_en && bus.addr == `TMB_ADDR_CTRL_A && bus.wdata[`TMB_CA_FORCE_B])) begin
        ob_q <= !ob_q;
      end
    end
  end
  assign compare_a_output_o = oa_q;
  assign compare_b_output_o = ob_q;

  // read mux: high locations of count and capture return the holder
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q <= `TMB_RST_BYTE;
    end else if (bus.rd_en) begin
      if (bus.addr == `TMB_ADDR_CTRL_A) begin
        rdata_q <= control_a_q;
      end else if (bus.addr == `TMB_ADDR_CTRL_B) begin
        rdata_q <= control_b_q;
      end else if (bus.addr == `TMB_ADDR_COUNT_LO) begin
        rdata_q <= count_value_q[7:0];
      end else if (bus.addr == `TMB_ADDR_COUNT_HI || bus.addr == `TMB_ADDR_CAPT_HI) begin
        rdata_q <= hold_q;
      end else if (bus.addr == `TMB_ADDR_CMPA_LO) begin
        rdata_q <= cmpa_buf_q[7:0];
      end else if (bus.addr == `TMB_ADDR_CMPA_HI) begin
        rdata_q <= cmpa_buf_q[15:8];
      end else if (bus.addr == `TMB_ADDR_CMPB_LO) begin
        rdata_q <= cmpb_buf_q[7:0];
      end else if (bus.addr == `TMB_ADDR_CMPB_HI) begin
        rdata_q <= cmpb_buf_q[15:8];
      end else if (bus.addr == `TMB_ADDR_CAPT_LO) begin
        rdata_q <= capture_value_q[7:0];
      end else if (bus.addr == `TMB_ADDR_FLAGS) begin
        rdata_q <= {2'b00, flag_q, 2'b00};
      end else if (bus.addr == `TMB_ADDR_MASK) begin
        rdata_q <= {2'b00, mask_q, 2'b00};
      end else begin
        rdata_q <= {7'h00, ext_lvl};
      end
    end
  end
  assign bus.rdata = rdata_q;
endmodule // tmb_timer

//--- core/tmb_cpu_port.sv
// processor-side end: classic wishbone slave that turns word orders into ordered byte pairs
// assumes one wishbone master on the same clock; software keeps interrupts out of a pair itself
`timescale 1ns/1ns
`include "tmb_params.svh"
module tmb_cpu_port (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [5:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  tmb_bus_if.cpu           bus
);
  typedef enum logic [2:0] {ST_IDLE, ST_FIRST, ST_SECOND, ST_WAIT, ST_LAST, ST_ACK} tmb_port_st_t;
  tmb_port_st_t st_q;
  logic [3:0]  base_q;
  logic        wide_q;
  logic        we_q;
  logic [15:0] wd_q;
  logic [7:0]  rd_q;
  logic [3:0]  addr_q;
  logic        wr_q;
  logic        rd_q1;
  logic [7:0]  wdat_q;
  logic        lo_first;

  // locations with a low/high pair; word access covers both bytes
  function automatic logic is_wide(input logic [3:0] a);
    return (a == `TMB_ADDR_COUNT_LO) || (a == `TMB_ADDR_CMPA_LO) ||
           (a == `TMB_ADDR_CMPB_LO) || (a == `TMB_ADDR_CAPT_LO);
  endfunction

  // write sends high then low; read fetches low then high
  assign lo_first = !we_q;

  // sequencer: one or two byte strobes, then a one-cycle ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q      <= ST_IDLE;
      base_q    <= 4'h0;
      wide_q    <= 1'b0;
      we_q      <= 1'b0;
      wd_q      <= 16'h0000;
      rd_q      <= 8'h00;
      addr_q    <= 4'h0;
      wr_q      <= 1'b0;
      rd_q1     <= 1'b0;
      wdat_q    <= 8'h00;
      wb_dat_o  <= 32'h0000_0000;
    end else begin
      wr_q  <= 1'b0;
      rd_q1 <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
            base_q <= wb_adr_i[5:2];
            wide_q <= is_wide(wb_adr_i[5:2]) && (wb_sel_i[1:0] == 2'b11);
            we_q   <= wb_we_i;
            wd_q   <= wb_dat_i[15:0];
            st_q   <= ST_FIRST;
          end
        end
        ST_FIRST: begin
          addr_q <= (wide_q && !lo_first) ? base_q + 4'h1 : base_q;
          wdat_q <= (wide_q && !lo_first) ? wd_q[15:8] : wd_q[7:0];
          wr_q   <= we_q;
          rd_q1  <= !we_q;
          st_q   <= ST_SECOND;
        end
        // second strobe for a pair only; a single byte just lets its read data settle
        ST_SECOND: begin
          addr_q <= we_q ? base_q : base_q + 4'h1;
          wdat_q <= wd_q[7:0];
          wr_q   <= we_q && wide_q;
          rd_q1  <= !we_q && wide_q;
          st_q   <= ST_WAIT;
        end
        // read data stands the cycle after its strobe: first byte here, a pair's high byte next
        ST_WAIT: begin
          if (!we_q) begin
            rd_q     <= bus.rdata;
            wb_dat_o <= {24'h00_0000, bus.rdata};
          end
          st_q <= wide_q ? ST_LAST : ST_ACK;
        end
        ST_LAST: begin
          if (!we_q) begin
            wb_dat_o <= {16'h0000, bus.rdata, rd_q};
          end
          st_q <= ST_ACK;
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign wb_ack_o  = (st_q == ST_ACK);
  assign bus.addr  = addr_q;
  assign bus.wr_en = wr_q;
  assign bus.rd_en = rd_q1;
  assign bus.wdata = wdat_q;
endmodule // tmb_cpu_port

//--- verif/tmb_bus_assertions.sv
// checker for the byte bus between the timer and its access end
// assumes instantiation beside the interface in tb_top and one shared clock
`timescale 1ns/1ns
module tmb_bus_assertions (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [3:0] addr,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  input  wire logic [7:0] wdata,
  input  wire logic [7:0] rdata
);
  logic [7:0]  hold_q;
  logic [15:0] cmpa_q;
  logic [15:0] cnt_q;
  logic [7:0]  ctlb_q;
  logic        cnt_ok_q;

  // shadow of cpu-written state; count shadow trusted only while the clock is off
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_q   <= 8'h00;
      cmpa_q   <= 16'h0000;
      cnt_q    <= 16'h0000;
      ctlb_q   <= 8'h00;
      cnt_ok_q <= 1'b1;
    end else if (wr_en) begin
      if (addr[0] && addr > 4'h2 && addr < 4'hA) hold_q <= wdata;
      if (addr == 4'h4) cmpa_q <= {hold_q, wdata};
      if (addr == 4'h2) cnt_q <= {hold_q, wdata};
      if (addr == 4'h2) cnt_ok_q <= (ctlb_q[2:0] == 3'h0);
      if (addr == 4'h1) ctlb_q <= wdata;
      if (addr == 4'h1 && wdata[2:0] != 3'h0) cnt_ok_q <= 1'b0;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_no_both; !(wr_en && rd_en); endproperty
  a_no_both: assert property (p_no_both) else $error("read and write strobes together");
  property p_hi_then_lo; wr_en && addr[0] && addr > 4'h2 && addr < 4'hA |=> wr_en && addr == $past(addr) - 4'h1;
  endproperty
  a_hi_then_lo: assert property (p_hi_then_lo) else $error("high byte write not followed by low");
  property p_lo_then_hi; rd_en && !addr[0] && addr > 4'h1 && addr < 4'hA |=> rd_en && addr == $past(addr) + 4'h1;
  endproperty
  a_lo_then_hi: assert property (p_lo_then_hi) else $error("low byte read not followed by high");
  property p_lo_alone; wr_en && !addr[0] && addr > 4'h1 && addr < 4'hA |=> !wr_en && !rd_en; endproperty
  a_lo_alone: assert property (p_lo_alone) else $error("strobe right after low byte write");
  property p_cmpa_lo; rd_en && addr == 4'h4 |=> rdata == cmpa_q[7:0]; endproperty
  a_cmpa_lo: assert property (p_cmpa_lo) else $error("compare a low byte wrong");
  property p_cmpa_hi; rd_en && addr == 4'h5 |=> rdata == cmpa_q[15:8]; endproperty
  a_cmpa_hi: assert property (p_cmpa_hi) else $error("compare a high byte wrong");
  property p_cnt_lo; rd_en && addr == 4'h2 && cnt_ok_q |=> rdata == cnt_q[7:0]; endproperty
  a_cnt_lo: assert property (p_cnt_lo) else $error("stopped count low byte moved");
  property p_cnt_hi; (rd_en && addr == 4'h2 && cnt_ok_q) ##1 (rd_en && addr == 4'h3) |=> rdata == cnt_q[15:8];
  endproperty
  a_cnt_hi: assert property (p_cnt_hi) else $error("count high byte not from holder");
  property p_ctlb; rd_en && addr == 4'h1 |=> rdata == ctlb_q; endproperty
  a_ctlb: assert property (p_ctlb) else $error("control b readback wrong");
  property p_rst; $fell(rst_i) |-> rdata == 8'h00; endproperty
  a_rst: assert property (p_rst) else $error("read data not cleared by reset");
endmodule // tmb_bus_assertions

//--- verif/tb_top.sv
// self-checking bench: wishbone master on the access end, timer behind the byte bus
// assumes both design ends and the checker compile alongside; one 125 MHz clock
`timescale 1ns/1ns
module tb_top;
  localparam logic [3:0] SB = 4'h1; // byte lane
  localparam logic [3:0] SW = 4'h3; // 16-bit pair
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc = 1'b0;
  logic        wb_stb = 1'b0;
  logic        wb_we = 1'b0;
  logic [5:0]  wb_adr = 6'h00;
  logic [31:0] wb_dat = 32'h0000_0000;
  logic [3:0]  wb_sel = 4'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack;
  logic        ext_pin = 1'b0;
  logic        cap_pin = 1'b0;
  logic        acomp = 1'b0;
  logic        irq;
  logic        bottom;
  logic        max_flag;
  logic        oa;
  logic        ob;
  logic [15:0] rq;
  int          error_cnt = 0;
  int          checks = 0;
  int          cyc_cnt = 0;

  tmb_bus_if bus ();
  tmb_timer i_tmb_timer (.clk_i(clk_i), .rst_i(rst_i), .bus(bus), .external_clock_pin_i(ext_pin),
    .capture_pin_i(cap_pin), .acomp_out_i(acomp), .compare_a_output_o(oa), .compare_b_output_o(ob),
    .irq_o(irq), .bottom_o(bottom), .max_o(max_flag));
  tmb_cpu_port i_tmb_cpu_port (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat), .wb_sel_i(wb_sel), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack), .bus(bus));
  tmb_bus_assertions i_chk (.clk_i(clk_i), .rst_i(rst_i), .addr(bus.addr), .wr_en(bus.wr_en),
    .rd_en(bus.rd_en), .wdata(bus.wdata), .rdata(bus.rdata));

  always #4 clk_i = ~clk_i;

  // cut a hang short; whole run needs well under a thousand cycles
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      $display("unexpected at %0t: run timed out", $time);
      stop_test();
    end
  end

  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // one classic cycle; request held until ack is sampled high, only the run timeout ends the wait
  task automatic wb(input logic w, input logic [3:0] idx, input logic [3:0] s, input logic [15:0] d,
                    output logic [15:0] q);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= {idx, 2'b00};
    wb_dat <= {16'h0000, d};
    wb_sel <= s;
    do begin
      @(posedge clk_i);
    end while (wb_ack !== 1'b1);
    q = wb_dat_o[15:0];
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask

  task automatic t_reset();
    for (int i = 1; i < 5; i++) begin
      wb(1'b0, 4'(2 * i), SW, 16'h0000, rq);
      chk(rq, 16'h0000, "wide register after reset");
    end
    chk({15'h0000, bottom}, 16'h0001, "bottom after reset");
  endtask

  task automatic t_ctrl();
    wb(1'b1, 4'h0, SB, 16'h00C3, rq);
    wb(1'b0, 4'h0, SB, 16'h0000, rq);
    chk({8'h00, rq[7:0]}, 16'h0003, "control a force bits read back");
    chk({14'h0000, oa, ob}, 16'h0003, "force strobes toggle both outputs");
    wb(1'b1, 4'h1, SB, 16'h0018, rq);
    wb(1'b0, 4'h1, SB, 16'h0000, rq);
    chk({8'h00, rq[7:0]}, 16'h0018, "control b single byte");
    wb(1'b1, 4'h0, SB, 16'h0000, rq);
    wb(1'b1, 4'h1, SB, 16'h0000, rq);
  endtask

  task automatic t_cmp();
    wb(1'b1, 4'h4, SW, 16'h1234, rq);
    wb(1'b1, 4'h6, SW, 16'hABCD, rq);
    wb(1'b0, 4'h4, SW, 16'h0000, rq);
    chk(rq, 16'h1234, "compare a after other write");
    wb(1'b0, 4'h6, SW, 16'h0000, rq);
    chk(rq, 16'hABCD, "compare b pair");
  endtask

  task automatic t_count();
    wb(1'b1, 4'h2, SW, 16'h01FF, rq);
    repeat (20) @(posedge clk_i);
    wb(1'b0, 4'h2, SW, 16'h0000, rq);
    chk(rq, 16'h01FF, "stopped count");
    wb(1'b1, 4'h2, SW, 16'hFFFF, rq);
    repeat (2) @(posedge clk_i);
    chk({14'h0000, max_flag, bottom}, 16'h0002, "max at all ones");
    wb(1'b1, 4'h2, SW, 16'h0000, rq);
    repeat (2) @(posedge clk_i);
    chk({14'h0000, max_flag, bottom}, 16'h0001, "bottom at zero");
  endtask

  task automatic t_run();
    wb(1'b1, 4'hB, SB, 16'h0010, rq);
    wb(1'b1, 4'h4, SW, 16'h0010, rq);
    wb(1'b1, 4'h1, SB, 16'h0001, rq);
    repeat (40) @(posedge clk_i);
    wb(1'b1, 4'h1, SB, 16'h0000, rq);
    wb(1'b0, 4'hA, SB, 16'h0000, rq);
    chk({8'h00, rq[7:0]}, 16'h0010, "compare a flag");
    chk({15'h0000, irq}, 16'h0001, "request unmasked");
    wb(1'b0, 4'h2, SW, 16'h0000, rq);
    chk({15'h0000, rq > 16'h0010 && rq < 16'h0100}, 16'h0001, "count advanced");
    chk({14'h0000, oa, ob}, 16'h0001, "compare a output toggled on match");
    wb(1'b1, 4'hB, SB, 16'h0000, rq);
    chk({15'h0000, irq}, 16'h0000, "request masked");
    wb(1'b1, 4'hB, SB, 16'h0010, rq);
    wb(1'b1, 4'hA, SB, 16'h0010, rq);
    chk({15'h0000, irq}, 16'h0000, "flag cleared");
  endtask

  task automatic t_capture();
    wb(1'b1, 4'h1, SB, 16'h0040, rq);
    wb(1'b1, 4'h2, SW, 16'h0321, rq);
    cap_pin <= 1'b1;
    repeat (12) @(posedge clk_i);
    wb(1'b0, 4'h8, SW, 16'h0000, rq);
    chk(rq, 16'h0321, "captured count");
    wb(1'b0, 4'hA, SB, 16'h0000, rq);
    chk({8'h00, rq[7:0]}, 16'h0020, "capture flag");
    wb(1'b1, 4'hA, SB, 16'h0020, rq);
    // comparator as capture source, rising edge
    wb(1'b1, 4'h2, SW, 16'h0456, rq);
    wb(1'b1, 4'h1, SB, 16'h0060, rq);
    acomp <= 1'b1;
    repeat (12) @(posedge clk_i);
    wb(1'b0, 4'h8, SW, 16'h0000, rq);
    chk(rq, 16'h0456, "comparator edge captured count");
  endtask

  task automatic t_ext();
    wb(1'b1, 4'h2, SW, 16'h0000, rq);
    wb(1'b1, 4'h1, SB, 16'h0007, rq);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_i) ext_pin <= 1'b1;
      repeat (4) @(posedge clk_i);
      ext_pin <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
    repeat (8) @(posedge clk_i);
    wb(1'b1, 4'h1, SB, 16'h0000, rq);
    wb(1'b0, 4'h2, SW, 16'h0000, rq);
    chk(rq, 16'h0003, "pin rising edges counted");
  endtask

  // reset for four cycles, then the scenarios in turn
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_ctrl();
    t_cmp();
    t_count();
    t_run();
    t_capture();
    t_ext();
    stop_test();
  end
endmodule // tb_top
